// ---- core/pft_top.sv ----
// Purpose: fault, sense, watchdog, openload and inrush/cooling timing
// Assumes: fault and select inputs synchronous to mclk except failsafe_input
// Notes: times use typical values; long counts are parameters
`timescale 1ns/1ps
module pft_top
  import pft_pkg::*;
#(
  parameter int SENSE_CYCLES = pft_pkg::SENSE_CYC,
  parameter int WDOG_CYCLES = pft_pkg::WDOG_CYC,
  parameter int OLLED_CYCLES = pft_pkg::OLLED_CYC,
  parameter int US_CYCLES = pft_pkg::CLK_MHZ
)
(
  input wire logic mclk, // 50 MHz clock
  input wire logic rst, // async reset, high
  input wire logic fault_detect, // any of the four faults present
  input wire logic overtemp_fault, // fault type flags
  input wire logic overcurrent_fault, // fault type flags
  input wire logic severe_short_fault, // fault type flags
  input wire logic undervoltage_fault, // fault type flags
  input wire logic output_cmd, // requested output state
  input wire logic sense_select, // pulse: new sense source chosen
  input wire logic failsafe_input, // pin, high when left open
  input wire logic wdog_kick, // pulse: host serviced watchdog
  input wire logic direct_in, // direct input command
  input wire logic led_mode, // openload check enabled for LEDs
  input wire logic pwm_en, // PWM module enabled
  input wire logic clk_internal, // 1 internal, 0 external clock
  input wire logic pwm_period_tick, // pulse: external PWM period end
  input wire logic inrush_start, // pulse: start overcurrent profile
  input wire logic cooling_start, // pulse: start cooling profile
  input wire logic [1:0] overcurrent_profile_sel, // inrush timing
  input wire logic [1:0] cooling_time_sel, // cooling timing
  output logic fault_status_pin_n, // low when fault reported
  output logic high_side_output, // switch drive
  output logic current_sense_valid, // sense output settled
  output logic failsafe_active, // watchdog expired
  output logic openload_check, // pulse: run openload check
  output logic clock_fail_enable, // clock-fail detector armed
  output logic [2:0] inrush_step, // current inrush step
  output logic inrush_busy, // inrush profile running
  output logic [2:0] cooling_step, // current cooling step
  output logic cooling_busy // cooling profile running
);
  import pft_pkg::*;

  initial
  begin
    if (SENSE_CYCLES < 1 || WDOG_CYCLES < 1 || OLLED_CYCLES < 1 || US_CYCLES < 1)
      $error("pft_top: cycle counts must be positive");
  end

  localparam int BC_CYC_MS = US_CYCLES * 1000;

  pft_fault_e f_state_reg, f_state_next;
  logic [31:0] f_cnt_reg, f_cnt_next;
  logic fs_n_reg, fs_n_next, hs_reg, hs_next;
  logic [31:0] s_cnt_reg, s_cnt_next;
  logic sv_reg, sv_next;
  logic [2:0] fsi_sync_reg;
  logic fsi_reg, fsi_next;
  logic [31:0] w_cnt_reg, w_cnt_next;
  logic fsa_reg, fsa_next;
  logic [31:0] o_cnt_reg, o_cnt_next;
  logic ol_reg, ol_next, cfe_reg, cfe_next;
  logic [31:0] i_cnt_reg, i_cnt_next;
  logic [2:0] i_step_reg, i_step_next;
  logic i_busy_reg, i_busy_next;
  logic [1:0] i_sel_reg, i_sel_next;
  logic [31:0] c_cnt_reg, c_cnt_next;
  logic [2:0] c_step_reg, c_step_next;
  logic c_busy_reg, c_busy_next;
  logic [1:0] c_sel_reg, c_sel_next;
  logic shut_fault;

  function automatic logic [31:0] oc_cycles(input logic [1:0] sel, input logic [2:0] st);
    oc_cycles = 32'(OC_US[sel][st] * US_CYCLES);
  endfunction

  function automatic logic [31:0] bc_cycles(input logic [1:0] sel, input logic [2:0] st);
    bc_cycles = 32'(BC_MS[sel][st] * BC_CYC_MS);
  endfunction

  assign shut_fault = overtemp_fault | overcurrent_fault | severe_short_fault |
                      undervoltage_fault;

  always_comb
  begin
    f_state_next = f_state_reg;
    f_cnt_next = f_cnt_reg;
    fs_n_next = fs_n_reg;
    hs_next = hs_reg;
    case (f_state_reg)
      PFT_IDLE:
      begin
        hs_next = output_cmd;
        fs_n_next = 1'b1;
        f_cnt_next = 32'h0;
        if (fault_detect)
          f_state_next = PFT_BLANK;
      end
      PFT_BLANK:
      begin
        hs_next = output_cmd;
        if (!fault_detect)
          f_state_next = PFT_IDLE;
        else if (f_cnt_reg >= 32'(BLANK_CYC - 1))
        begin
          fs_n_next = 1'b0;
          f_cnt_next = 32'h0;
          f_state_next = PFT_FLAG;
        end
        else
          f_cnt_next = f_cnt_reg + 32'h1;
      end
      PFT_FLAG:
      begin
        hs_next = output_cmd;
        if (!shut_fault && !fault_detect)
          f_state_next = PFT_IDLE;
        else if (shut_fault && f_cnt_reg >= 32'(SHUT_CYC - 1))
        begin
          hs_next = 1'b0;
          f_state_next = PFT_OFF;
        end
        else if (shut_fault)
          f_cnt_next = f_cnt_reg + 32'h1;
      end
      PFT_OFF:
      begin
        hs_next = 1'b0;
        if (!fault_detect && !shut_fault && !output_cmd)
          f_state_next = PFT_IDLE;
      end
      default: f_state_next = PFT_IDLE;
    endcase
  end

  always_comb
  begin
    s_cnt_next = s_cnt_reg;
    sv_next = sv_reg;
    if (sense_select)
    begin
      s_cnt_next = 32'h0;
      sv_next = 1'b0;
    end
    else if (!sv_reg)
    begin
      if (s_cnt_reg >= 32'(SENSE_CYCLES - 1))
        sv_next = 1'b1;
      else
        s_cnt_next = s_cnt_reg + 32'h1;
    end
  end

  always_comb
  begin
    // change accepted only when second and third stages agree
    fsi_next = (fsi_sync_reg[1] == fsi_sync_reg[2]) ? fsi_sync_reg[2] : fsi_reg;
    w_cnt_next = w_cnt_reg;
    fsa_next = fsa_reg;
    if (!fsi_reg || wdog_kick)
    begin
      w_cnt_next = 32'h0;
      fsa_next = 1'b0;
    end
    else if (!fsa_reg)
    begin
      if (w_cnt_reg >= 32'(WDOG_CYCLES - 1))
        fsa_next = 1'b1;
      else
        w_cnt_next = w_cnt_reg + 32'h1;
    end
  end

  always_comb
  begin
    o_cnt_next = o_cnt_reg;
    ol_next = 1'b0;
    cfe_next = pwm_en & ~clk_internal;
    if (!led_mode)
      o_cnt_next = 32'h0;
    else if (pwm_en && !clk_internal)
      ol_next = pwm_period_tick;
    else if (o_cnt_reg >= 32'(OLLED_CYCLES - 1))
    begin
      o_cnt_next = 32'h0;
      ol_next = 1'b1;
    end
    else
      o_cnt_next = o_cnt_reg + 32'h1;
  end

  always_comb
  begin
    i_cnt_next = i_cnt_reg;
    i_step_next = i_step_reg;
    i_busy_next = i_busy_reg;
    i_sel_next = i_sel_reg;
    if (inrush_start)
    begin
      i_sel_next = overcurrent_profile_sel;
      i_cnt_next = 32'h0;
      i_step_next = 3'h0;
      i_busy_next = 1'b1;
    end
    else if (i_busy_reg)
    begin
      if (i_cnt_reg >= oc_cycles(i_sel_reg, i_step_reg) - 32'h1)
      begin
        i_cnt_next = 32'h0;
        if (i_step_reg == 3'(OC_STEPS - 1))
          i_busy_next = 1'b0;
        else
          i_step_next = i_step_reg + 3'h1;
      end
      else
        i_cnt_next = i_cnt_reg + 32'h1;
    end
  end

  always_comb
  begin
    c_cnt_next = c_cnt_reg;
    c_step_next = c_step_reg;
    c_busy_next = c_busy_reg;
    c_sel_next = c_sel_reg;
    if (cooling_start)
    begin
      c_sel_next = cooling_time_sel;
      c_cnt_next = 32'h0;
      c_step_next = 3'h0;
      c_busy_next = 1'b1;
    end
    else if (c_busy_reg)
    begin
      if (c_cnt_reg >= bc_cycles(c_sel_reg, c_step_reg) - 32'h1)
      begin
        c_cnt_next = 32'h0;
        if (c_step_reg == 3'(BC_STEPS - 1))
          c_busy_next = 1'b0;
        else
          c_step_next = c_step_reg + 3'h1;
      end
      else
        c_cnt_next = c_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      f_state_reg <= PFT_IDLE;
      f_cnt_reg <= 32'h0;
      fs_n_reg <= 1'b1;
      hs_reg <= 1'b0;
      s_cnt_reg <= 32'h0;
      sv_reg <= 1'b0;
      fsi_sync_reg <= 3'h0;
      fsi_reg <= 1'b0;
      w_cnt_reg <= 32'h0;
      fsa_reg <= 1'b0;
      o_cnt_reg <= 32'h0;
      ol_reg <= 1'b0;
      cfe_reg <= 1'b0;
      i_cnt_reg <= 32'h0;
      i_step_reg <= 3'h0;
      i_busy_reg <= 1'b0;
      i_sel_reg <= SEL_00;
      c_cnt_reg <= 32'h0;
      c_step_reg <= 3'h0;
      c_busy_reg <= 1'b0;
      c_sel_reg <= SEL_00;
    end
    else
    begin
      f_state_reg <= f_state_next;
      f_cnt_reg <= f_cnt_next;
      fs_n_reg <= fs_n_next;
      hs_reg <= fsa_next ? direct_in : hs_next;
      s_cnt_reg <= s_cnt_next;
      sv_reg <= sv_next;
      fsi_sync_reg <= {fsi_sync_reg[1:0], failsafe_input};
      fsi_reg <= fsi_next;
      w_cnt_reg <= w_cnt_next;
      fsa_reg <= fsa_next;
      o_cnt_reg <= o_cnt_next;
      ol_reg <= ol_next;
      cfe_reg <= cfe_next;
      i_cnt_reg <= i_cnt_next;
      i_step_reg <= i_step_next;
      i_busy_reg <= i_busy_next;
      i_sel_reg <= i_sel_next;
      c_cnt_reg <= c_cnt_next;
      c_step_reg <= c_step_next;
      c_busy_reg <= c_busy_next;
      c_sel_reg <= c_sel_next;
    end
  end

  assign fault_status_pin_n = fs_n_reg;
  assign high_side_output = hs_reg;
  assign current_sense_valid = sv_reg;
  assign failsafe_active = fsa_reg;
  assign openload_check = ol_reg;
  assign clock_fail_enable = cfe_reg;
  assign inrush_step = i_step_reg;
  assign inrush_busy = i_busy_reg;
  assign cooling_step = c_step_reg;
  assign cooling_busy = c_busy_reg;
endmodule

// ---- core/pft_pkg.sv ----
// Purpose: constants for the protection fault timing engine
// Assumes: 50 MHz mclk
// Notes: overcurrent table in microseconds, cooling table in milliseconds, converted to cycles at elaboration
package pft_pkg;
  localparam int CLK_MHZ = 50;
  localparam int BLANK_NS = 5000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int SHUT_NS = 7000;
  localparam int SHUT_CYC = (SHUT_NS * CLK_MHZ) / 1000;
  localparam int SENSE_US = 70;
  localparam int SENSE_CYC = SENSE_US * CLK_MHZ;
  localparam int WDOG_MS = 310;
  localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
  localparam int OLLED_US = 8300;
  localparam int OLLED_CYC = OLLED_US * CLK_MHZ;
  localparam int OC_STEPS = 7;
  localparam int BC_STEPS = 6;
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  localparam logic [1:0] SEL_11 = 2'h3;
  localparam int OC_NUM = 7;
  // overcurrent steps in us, index [sel][step]
  localparam int OC_US [4][7] = '{
    '{5000, 1720, 2000, 3000, 5000, 12200, 44600},
    '{2480, 800, 1040, 1580, 2240, 6120, 22200},
    '{9800, 3200, 4200, 5800, 9800, 24400, 89200},
    '{19600, 6400, 8400, 11600, 19600, 48800, 178400}};
  // bulb cooling steps in ms, index [sel][step]; 11 reuses medium
  localparam int BC_MS [4][6] = '{
    '{834, 448, 510, 596, 718, 898},
    '{418, 224, 254, 290, 360, 648},
    '{1668, 894, 1022, 1192, 1434, 1796},
    '{834, 448, 510, 596, 718, 898}};
  typedef enum logic [1:0] {
    PFT_IDLE = 2'b00,
    PFT_BLANK = 2'b01,
    PFT_FLAG = 2'b10,
    PFT_OFF = 2'b11
  } pft_fault_e;
endpackage

// ---- verification/pft_asserts.sv ----
// Purpose: port timing checks for pft_top
// Assumes: one mclk domain, rst async high
// Notes: fault and sense delays checked in a narrow window
`timescale 1ns/1ps
module pft_asserts
  import pft_pkg::*;
#(
  parameter int SENSE_CYCLES = 20
)
(
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic fault_detect, // in
  input wire logic output_cmd, // in
  input wire logic sense_select, // in
  input wire logic led_mode, // in
  input wire logic pwm_en, // in
  input wire logic clk_internal, // in
  input wire logic pwm_period_tick, // in
  input wire logic inrush_start, // in
  input wire logic cooling_start, // in
  input wire logic fault_status_pin_n, // out
  input wire logic high_side_output, // out
  input wire logic current_sense_valid, // out
  input wire logic openload_check, // out
  input wire logic clock_fail_enable, // out
  input wire logic [2:0] inrush_step, // out
  input wire logic inrush_busy, // out
  input wire logic [2:0] cooling_step, // out
  input wire logic cooling_busy // out
);
  localparam int SLO = SENSE_CYCLES - 1;
  localparam int SHI = SENSE_CYCLES + 2;
  logic [9:0] fcnt_reg;
  logic [9:0] fcnt_next;
  // saturates so a long fault cannot wrap into the blanking window
  always_comb
  begin
    fcnt_next = !fault_detect ? 10'h000 : (&fcnt_reg ? fcnt_reg : fcnt_reg + 10'h001);
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      fcnt_reg <= 10'h000;
    else
      fcnt_reg <= fcnt_next;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_CLKFAIL: assert property (clock_fail_enable == $past(pwm_en && !clk_internal))
    else $error("clock fail enable wrong");
  AST_OL_EXT: assert property (led_mode && pwm_en && !clk_internal && pwm_period_tick |=> openload_check)
    else $error("openload check missed period end");
  AST_OL_ONE: assert property (openload_check |=> !openload_check)
    else $error("openload check longer than one cycle");
  AST_BLANK: assert property ($fell(fault_status_pin_n) |-> fcnt_reg inside {[10'h0F8:10'h0FD]})
    else $error("fault flagged outside blanking time");
  AST_SHUT: assert property ($fell(high_side_output) && $past(output_cmd) |-> !fault_status_pin_n)
    else $error("output off without fault");
  AST_SENSE: assert property (sense_select |=> !current_sense_valid ##[SLO:SHI] current_sense_valid)
    else $error("sense valid time wrong");
  AST_INRUSH: assert property (inrush_start |=> inrush_busy && inrush_step == 3'h0)
    else $error("inrush start wrong");
  AST_COOL: assert property (cooling_start |=> cooling_busy && cooling_step == 3'h0)
    else $error("cooling start wrong");
  AST_STEP: assert property ($changed(inrush_step) && inrush_busy && !$past(inrush_start)
    |-> inrush_step == $past(inrush_step) + 3'h1)
    else $error("inrush step skipped");
endmodule

// ---- verification/pft_host.sv ----
// Purpose: host side source of external PWM period ticks
// Assumes: ticks change on the falling edge
// Notes: stands still while run is low
`timescale 1ns/1ps
module pft_host
#(
  parameter int PERIOD = 30
)
(
  input wire logic mclk, // clock
  input wire logic run, // make ticks
  output logic tick // period end pulse
);
  int cnt;
  initial tick = 1'b0;
  always @(negedge mclk)
  begin
    cnt = run ? (cnt + 1) % PERIOD : 0;
    tick <= run && cnt == PERIOD - 1;
  end
endmodule

// ---- verification/tb.sv ----
// Purpose: self-checking bench for pft_top
// Assumes: short parameters, one cycle per profile microsecond
// Notes: cooling profiles too long to walk, only starts checked
`timescale 1ns/1ps
module tb;
  import pft_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic fault_detect = 1'b0, overtemp_fault = 1'b0, overcurrent_fault = 1'b0;
  logic severe_short_fault = 1'b0, undervoltage_fault = 1'b0, output_cmd = 1'b0;
  logic sense_select = 1'b0, failsafe_input = 1'b0, wdog_kick = 1'b0, direct_in = 1'b0;
  logic led_mode = 1'b0, pwm_en = 1'b0, clk_internal = 1'b0, tick_run = 1'b0;
  logic inrush_start = 1'b0, cooling_start = 1'b0, pwm_period_tick;
  logic [1:0] overcurrent_profile_sel = 2'h0, cooling_time_sel = 2'h0;
  logic fault_status_pin_n, high_side_output, current_sense_valid, failsafe_active;
  logic openload_check, clock_fail_enable, inrush_busy, cooling_busy;
  logic [2:0] inrush_step, cooling_step;
  int bad_count = 0, comparisons = 0, n, k;
  pft_top #(.SENSE_CYCLES(20), .WDOG_CYCLES(100), .OLLED_CYCLES(50), .US_CYCLES(1)) dut (.*);
  pft_host #(.PERIOD(30)) host (.mclk(mclk), .run(tick_run), .tick(pwm_period_tick));
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int near(input int v, input int e);
    return (v >= e - 2 && v <= e + 2) ? e : v;
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic waitv(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 5000)
    begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask
  task automatic step_len(output int c);
    logic [2:0] s;
    s = inrush_step;
    c = 0;
    while (inrush_step === s && inrush_busy === 1'b1 && c < 100000)
    begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask
  task automatic go_inrush(input logic [1:0] sel);
    @(negedge mclk);
    overcurrent_profile_sel = sel;
    inrush_start = 1'b1;
    @(negedge mclk);
    inrush_start = 1'b0;
  endtask
  task automatic t_fault();
    output_cmd = 1'b1;
    cyc(5);
    check(high_side_output, 1'b1);
    fault_detect = 1'b1;
    cyc(100);
    // a fault that drops during blanking must never reach the pin
    fault_detect = 1'b0;
    cyc(300);
    check(fault_status_pin_n, 1'b1);
    fault_detect = 1'b1;
    overcurrent_fault = 1'b1;
    waitv(fault_status_pin_n, 1'b0, n);
    check(near(n, BLANK_CYC + 1), BLANK_CYC + 1);
    check(high_side_output, 1'b1);
    waitv(high_side_output, 1'b0, n);
    check(near(n, SHUT_CYC), SHUT_CYC);
    @(negedge mclk);
    fault_detect = 1'b0;
    overcurrent_fault = 1'b0;
    output_cmd = 1'b0;
    cyc(5);
    check(fault_status_pin_n, 1'b1);
  endtask
  task automatic t_sense();
    sense_select = 1'b1;
    @(negedge mclk);
    sense_select = 1'b0;
    waitv(current_sense_valid, 1'b1, n);
    check(near(n, 21), 21);
  endtask
  task automatic t_openload();
    @(negedge mclk);
    led_mode = 1'b1;
    pwm_en = 1'b1;
    clk_internal = 1'b1;
    waitv(openload_check, 1'b1, n);
    waitv(openload_check, 1'b0, n);
    waitv(openload_check, 1'b1, n);
    check(n + 1, 50);
    @(negedge mclk);
    clk_internal = 1'b0;
    cyc(2);
    check(clock_fail_enable, 1'b1);
    tick_run = 1'b1;
    k = 0;
    repeat (300)
    begin
      @(posedge mclk);
      #1;
      k += openload_check;
    end
    check(near(k, 10), 10);
    @(negedge mclk);
    tick_run = 1'b0;
    pwm_en = 1'b0;
    cyc(2);
    check(clock_fail_enable, 1'b0);
  endtask
  task automatic t_profiles();
    go_inrush(SEL_01);
    step_len(n);
    check(near(n, OC_US[1][0]), OC_US[1][0]);
    // both slower selections must still sit in step 0 past the SEL_00 first step
    go_inrush(SEL_10);
    cyc(5100);
    check(inrush_step, 3'h0);
    go_inrush(SEL_11);
    cyc(5100);
    check(inrush_step, 3'h0);
    go_inrush(SEL_00);
    for (int i = 0; i < OC_STEPS; i++)
    begin
      step_len(n);
      check(near(n, OC_US[0][i]), OC_US[0][i]);
    end
    check(inrush_busy, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      @(negedge mclk);
      cooling_time_sel = 2'(s);
      cooling_start = 1'b1;
      @(negedge mclk);
      cooling_start = 1'b0;
      cyc(20);
      check({cooling_busy, cooling_step}, 4'h8);
    end
  endtask
  task automatic t_wdog();
    failsafe_input = 1'b1;
    repeat (6)
    begin
      cyc(50);
      wdog_kick = 1'b1;
      @(negedge mclk);
      wdog_kick = 1'b0;
    end
    check(failsafe_active, 1'b0);
    waitv(failsafe_active, 1'b1, n);
    check(near(n, 100), 100);
    @(negedge mclk);
    direct_in = 1'b1;
    cyc(3);
    check(high_side_output, 1'b1);
    direct_in = 1'b0;
    cyc(3);
    check(high_side_output, 1'b0);
  endtask
  task automatic end_of_test();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    check({fault_status_pin_n, high_side_output, failsafe_active, inrush_busy}, 4'h8);
    rst = 1'b0;
    cyc(2);
    t_fault();
    t_sense();
    t_openload();
    t_profiles();
    t_wdog();
    end_of_test();
  end
  initial
  begin
    // the scenarios need about 88k cycles; this limit is 95k cycles
    #1900000;
    bad_count++;
    end_of_test();
  end
endmodule
bind pft_top pft_asserts #(.SENSE_CYCLES(SENSE_CYCLES)) chk (.*);
